// ==== pbcg_defines.svh ====
`ifndef PBCG_DEFINES_SVH
`define PBCG_DEFINES_SVH

// ----------------------------------------------------------------
// Bus and register map
// ----------------------------------------------------------------
`define PBCG_ADDR_W 12
`define PBCG_DATA_W 32
`define PBCG_OFF_ENABLE 12'h000
`define PBCG_OFF_REQUEST 12'h004
`define PBCG_OFF_PENDING 12'h008

// ----------------------------------------------------------------
// Field layout of the enable register
// ----------------------------------------------------------------
`define PBCG_EXT_BIT 26
`define PBCG_DMA_BIT 24
`define PBCG_CONV_LSB 16
`define PBCG_CONV_MSB 19
`define PBCG_SER_LSB 0
`define PBCG_SER_MSB 15
`define PBCG_CONV_N 4
`define PBCG_SER_N 16
`define PBCG_GATE_N 22

// ----------------------------------------------------------------
// Masks and reset values
// ----------------------------------------------------------------
`define PBCG_FIELD_MASK 32'h050F_FFFF
`define PBCG_ENABLE_RST 32'h050F_FFFF
`define PBCG_ZERO_WORD 32'h0000_0000
`define PBCG_GATE_RST 22'h3F_FFFF
`define PBCG_CLK_HZ 40000000

`endif

// ==== pbcg_pkg.sv ====
package pbcg_pkg;
  `include "pbcg_defines.svh"

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [`PBCG_ADDR_W-1:0] paddr;
    logic [`PBCG_DATA_W-1:0] pwdata;
  } pbcg_apb_req_t;

  typedef struct packed {
    logic pready;
    logic pslverr;
    logic [`PBCG_DATA_W-1:0] prdata;
  } pbcg_apb_rsp_t;

  typedef struct packed {
    logic ext_bus_clk_en;
    logic dma_clk_en;
    logic [`PBCG_CONV_N-1:0] converter_clk_en;
    logic [`PBCG_SER_N-1:0] serial_chan_clk_en;
  } pbcg_enables_t;

  typedef enum logic [2:0] {
    PBCG_REG_ENABLE = 3'h1,
    PBCG_REG_REQUEST = 3'h2,
    PBCG_REG_PENDING = 3'h4
  } pbcg_reg_sel_t;
endpackage

// ==== pbcg_clk_gate_cell.sv ====
`timescale 1ns/10ps
module pbcg_clk_gate_cell #(
  parameter logic RESET_EN = 1'b1
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Control
  input wire logic enable_i,
  // Gated clock
  output logic gclk_o,
  output logic active_o
);
  logic en_low_reg;

  // ----------------------------------------------------------------
  // Enable held through the high phase
  // ----------------------------------------------------------------
  // Taken while the clock is low, so no high pulse is ever cut short
  always_ff @(negedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      en_low_reg <= RESET_EN;
    end else begin
      en_low_reg <= enable_i;
    end
  end

  assign gclk_o = clock_i & en_low_reg;
  assign active_o = en_low_reg;
endmodule

// ==== pbcg_apb_front.sv ====
`timescale 1ns/10ps
`include "pbcg_defines.svh"
module pbcg_apb_front
  import pbcg_pkg::*;
(
  // Bus request
  input pbcg_pkg::pbcg_apb_req_t req_i,
  // Decoded strobes
  output logic setup_o,
  output logic access_o,
  output logic wr_accept_o,
  output logic [2:0] sel_o,
  output logic err_o
);
  function automatic logic [2:0] pbcg_decode(input logic [`PBCG_ADDR_W-1:0] a);
    case (a)
      `PBCG_OFF_ENABLE: pbcg_decode = PBCG_REG_ENABLE;
      `PBCG_OFF_REQUEST: pbcg_decode = PBCG_REG_REQUEST;
      `PBCG_OFF_PENDING: pbcg_decode = PBCG_REG_PENDING;
      default: pbcg_decode = 3'h0;
    endcase
  endfunction

  wire logic [2:0] hit_w;
  wire logic ro_write_w;

  assign hit_w = pbcg_decode(req_i.paddr);
  // Only the enable word accepts writes; status words refuse them
  assign ro_write_w = req_i.pwrite && (hit_w != PBCG_REG_ENABLE);
  assign setup_o = req_i.psel && !req_i.penable;
  assign access_o = req_i.psel && req_i.penable;
  assign sel_o = hit_w;
  assign err_o = access_o && ((hit_w == 3'h0) || ro_write_w);
  assign wr_accept_o = access_o && req_i.pwrite && (hit_w == PBCG_REG_ENABLE);
endmodule

// ==== pbcg_gate_ctrl.sv ====
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/10ps
`include "pbcg_defines.svh"
// Operation
// - Bit 26 on passes the bus clock to the external bus interface, off blocks it.
// - The external bus enable reads 1 after reset.
// - With its clock blocked the external bus interface does nothing at all.
// - Bit 24 on clocks the DMA controller, off blocks its clock.
// - The DMA enable reads 1 after reset.
// - Bits 16 to 19 enable converter units 0 to 3 in order.
// - A converter bit on clocks its unit, off blocks it.
// - All four converter enables read 1 after reset.
// - Bits 15 to 0 enable serial channels 0 to 15, bit n for channel n.
// - A serial bit on clocks its channel, off blocks it.
// - All sixteen serial enables read 1 after reset.
// - Readback shows a new enable only once the clock change reached the peripheral.
module pbcg_gate_ctrl
  import pbcg_pkg::*;
#(
  parameter logic [31:0] IMPL_MASK = `PBCG_FIELD_MASK
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // Register bus
  input pbcg_pkg::pbcg_apb_req_t apb_req_i,
  output pbcg_pkg::pbcg_apb_rsp_t apb_rsp_o,
  // Gated peripheral clocks
  output logic ext_bus_clk_o,
  output logic dma_clk_o,
  output logic [`PBCG_CONV_N-1:0] converter_clk_o,
  output logic [`PBCG_SER_N-1:0] serial_chan_clk_o,
  // Applied enables
  output pbcg_pkg::pbcg_enables_t applied_o
);
  import pbcg_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [31:0] request_reg;
  logic [31:0] request_next;
  logic [31:0] applied_reg;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic first_reg;
  wire logic setup_w;
  wire logic access_w;
  wire logic wr_accept_w;
  wire logic [2:0] sel_w;
  wire logic err_w;
  wire logic [31:0] wmask_w;
  wire logic [31:0] active_word_w;
  wire logic [31:0] pending_w;
  wire logic [`PBCG_GATE_N-1:0] gate_en_w;
  wire logic [`PBCG_GATE_N-1:0] gate_act_w;
  wire logic [`PBCG_GATE_N-1:0] gclk_w;
  wire logic [`PBCG_GATE_N-1:0] applied_lane_w;

  // Lane order: ext bus, DMA, converters, serial channels
  function automatic logic [`PBCG_GATE_N-1:0] pbcg_lanes(input logic [31:0] w);
    pbcg_lanes = {
      w[`PBCG_EXT_BIT],
      w[`PBCG_DMA_BIT],
      w[`PBCG_CONV_MSB:`PBCG_CONV_LSB],
      w[`PBCG_SER_MSB:`PBCG_SER_LSB]
    };
  endfunction

  // ----------------------------------------------------------------
  // Bus front end
  // ----------------------------------------------------------------
  pbcg_apb_front u_front (
    .req_i(apb_req_i),
    .setup_o(setup_w),
    .access_o(access_w),
    .wr_accept_o(wr_accept_w),
    .sel_o(sel_w),
    .err_o(err_w)
  );

  // ----------------------------------------------------------------
  // Requested enables
  // ----------------------------------------------------------------
  // Reserved and absent bits keep their reset value whatever is written
  assign wmask_w = `PBCG_FIELD_MASK & IMPL_MASK;
  assign request_next = wr_accept_w
    ? ((apb_req_i.pwdata & wmask_w) | (request_reg & ~wmask_w))
    : request_reg;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      request_reg <= `PBCG_ENABLE_RST;
    end else begin
      request_reg <= request_next;
    end
  end

  // ----------------------------------------------------------------
  // Gate bank
  // ----------------------------------------------------------------
  assign gate_en_w = {
    request_reg[`PBCG_EXT_BIT],
    request_reg[`PBCG_DMA_BIT],
    request_reg[`PBCG_CONV_MSB:`PBCG_CONV_LSB],
    request_reg[`PBCG_SER_MSB:`PBCG_SER_LSB]
  };

  // One cell per peripheral clock, all reset enabled
  // Falling-edge flop instead of a latch: same hold, simpler timing
  generate
    for (genvar g = 0; g < `PBCG_GATE_N; g++) begin : g_gate
      pbcg_clk_gate_cell #(
        .RESET_EN(1'b1)
      ) u_cell (
        .clock_i(clock_i),
        .rst_n_i(rst_n_i),
        .enable_i(gate_en_w[g]),
        .gclk_o(gclk_w[g]),
        .active_o(gate_act_w[g])
      );
    end
  endgenerate

  // A blocked clock leaves the interface with no edges to act on
  assign ext_bus_clk_o = gclk_w[`PBCG_GATE_N-1];
  assign dma_clk_o = gclk_w[`PBCG_GATE_N-2];
  assign converter_clk_o = gclk_w[`PBCG_SER_N +: `PBCG_CONV_N];
  assign serial_chan_clk_o = gclk_w[`PBCG_SER_N-1:0];

  // ----------------------------------------------------------------
  // Applied enables
  // ----------------------------------------------------------------
  assign active_word_w = {
    5'h00,
    gate_act_w[`PBCG_GATE_N-1],
    1'b0,
    gate_act_w[`PBCG_GATE_N-2],
    4'h0,
    gate_act_w[`PBCG_SER_N +: `PBCG_CONV_N],
    gate_act_w[`PBCG_SER_N-1:0]
  };

  // Sampled one edge after the gate took the enable, i.e. at the
  // first edge that the peripheral sees with the new setting
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      applied_reg <= `PBCG_ENABLE_RST;
    end else begin
      applied_reg <= active_word_w;
    end
  end

  assign pending_w = request_reg ^ applied_reg;
  assign applied_lane_w = pbcg_lanes(applied_reg);
  assign applied_o.ext_bus_clk_en = applied_reg[`PBCG_EXT_BIT];
  assign applied_o.dma_clk_en = applied_reg[`PBCG_DMA_BIT];
  assign applied_o.converter_clk_en = applied_reg[`PBCG_CONV_MSB:`PBCG_CONV_LSB];
  assign applied_o.serial_chan_clk_en = applied_reg[`PBCG_SER_MSB:`PBCG_SER_LSB];

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  // Loaded in the setup cycle so the bus sees a flop with no wait
  assign prdata_next = !setup_w ? prdata_reg :
    (sel_w == PBCG_REG_ENABLE) ? applied_reg :
    (sel_w == PBCG_REG_REQUEST) ? request_reg :
    (sel_w == PBCG_REG_PENDING) ? pending_w :
    `PBCG_ZERO_WORD;

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      prdata_reg <= `PBCG_ZERO_WORD;
    end else begin
      prdata_reg <= prdata_next;
    end
  end

  assign apb_rsp_o.pready = 1'b1;
  assign apb_rsp_o.pslverr = err_w;
  assign apb_rsp_o.prdata = prdata_reg;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      first_reg <= 1'b1;
    end else begin
      first_reg <= 1'b0;
    end
  end

  AST_EXT_RESET: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    first_reg |-> applied_reg[`PBCG_EXT_BIT] && request_reg[`PBCG_EXT_BIT])
    else $error("External bus enable not set after reset");

  AST_DMA_RESET: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    first_reg |-> applied_reg[`PBCG_DMA_BIT] && gate_act_w[`PBCG_GATE_N-2])
    else $error("DMA enable not set after reset");

  AST_CONV_RESET: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    first_reg |-> &applied_reg[`PBCG_CONV_MSB:`PBCG_CONV_LSB])
    else $error("Converter enables not all set after reset");

  AST_SER_RESET: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    first_reg |-> &applied_reg[`PBCG_SER_MSB:`PBCG_SER_LSB])
    else $error("Serial enables not all set after reset");

  AST_EXT_FOLLOW: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    wr_accept_w && wmask_w[`PBCG_EXT_BIT]
    |=> ##1 applied_reg[`PBCG_EXT_BIT] == $past(apb_req_i.pwdata[`PBCG_EXT_BIT], 2))
    else $error("External bus gate did not follow the written bit");

  AST_EXT_BLOCKED: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    !applied_reg[`PBCG_EXT_BIT] && !request_reg[`PBCG_EXT_BIT]
    |-> !gate_act_w[`PBCG_GATE_N-1])
    else $error("External bus clock ran while blocked");

  AST_DMA_FOLLOW: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    $changed(request_reg[`PBCG_DMA_BIT])
    |=> applied_o.dma_clk_en == $past(request_reg[`PBCG_DMA_BIT]))
    else $error("DMA gate did not follow its enable");

  AST_CONV_MAP: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    $changed(request_reg[`PBCG_CONV_MSB:`PBCG_CONV_LSB])
    |=> applied_o.converter_clk_en == $past(request_reg[`PBCG_CONV_MSB:`PBCG_CONV_LSB]))
    else $error("Converter gates not mapped to their bits");

  AST_CONV_GATE: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    ##1 gate_act_w[`PBCG_SER_N +: `PBCG_CONV_N]
      == request_reg[`PBCG_CONV_MSB:`PBCG_CONV_LSB])
    else $error("Converter gate state differs from its enable");

  AST_SER_MAP: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    $changed(request_reg[`PBCG_SER_MSB:`PBCG_SER_LSB])
    |=> applied_o.serial_chan_clk_en == $past(request_reg[`PBCG_SER_MSB:`PBCG_SER_LSB]))
    else $error("Serial gates not mapped to their bits");

  AST_SER_GATE: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    ##1 gate_act_w[`PBCG_SER_N-1:0] == request_reg[`PBCG_SER_MSB:`PBCG_SER_LSB])
    else $error("Serial gate state differs from its enable");

  AST_READ_LAG: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    $changed(request_reg) |-> (applied_reg != request_reg) ##1 (pending_w == 32'h0000_0000)
      or ($changed(request_reg) ##1 $changed(request_reg)))
    else $error("Readback did not lag the gate by one edge");

  AST_GATE_ALIGN: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    $changed(gate_act_w) |-> gate_act_w == pbcg_lanes(request_reg) && $changed(gate_en_w))
    else $error("Gate switched off the bus clock alignment");

  AST_RESERVED_ZERO: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    ((request_reg & ~`PBCG_FIELD_MASK) == `PBCG_ZERO_WORD) [*2])
    else $error("Reserved bit became set");

  AST_ABSENT_HOLD: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    wr_accept_w |=> ((request_reg ^ `PBCG_ENABLE_RST) & ~wmask_w) == 32'h0000_0000)
    else $error("Absent peripheral enable left its reset value");

  // ----------------------------------------------------------------
  // Bus and lane checks
  // ----------------------------------------------------------------
  AST_READY_HIGH: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    access_w |-> apb_rsp_o.pready)
    else $error("Access phase without ready");

  AST_SLVERR_PHASE: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    access_w && !(|sel_w) |-> apb_rsp_o.pslverr)
    else $error("Unmapped access not refused");

  AST_ERR_NO_EFFECT: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    apb_rsp_o.pslverr |-> !wr_accept_w)
    else $error("Refused access was written");

  AST_REFUSED_WRITE: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    !wr_accept_w |=> $stable(request_reg))
    else $error("Enable word changed without a write");

  AST_PRDATA_HOLD: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    access_w |=> $stable(apb_rsp_o.prdata))
    else $error("Read data moved after the access");

  AST_READ_ENABLE: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    setup_w && (sel_w == PBCG_REG_ENABLE) |=> apb_rsp_o.prdata == $past(applied_reg))
    else $error("Enable read did not return the applied value");

  AST_READ_REQUEST: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    setup_w && (sel_w == PBCG_REG_REQUEST) |=> apb_rsp_o.prdata == $past(request_reg))
    else $error("Request read did not return the requested value");

  AST_READ_PENDING: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    setup_w && (sel_w == PBCG_REG_PENDING) |=> apb_rsp_o.prdata == $past(pending_w))
    else $error("Pending read did not return the pending value");

  AST_READ_UNMAPPED: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    setup_w && !(|sel_w) |=> apb_rsp_o.prdata == `PBCG_ZERO_WORD)
    else $error("Unmapped read returned data");

  AST_PENDING_IDLE: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    $stable(request_reg) |-> pending_w == `PBCG_ZERO_WORD)
    else $error("Readback still pending on a steady request");

  AST_DMA_BLOCKED: assert property (
    @(posedge clock_i) disable iff (!rst_n_i)
    !applied_reg[`PBCG_DMA_BIT] && !request_reg[`PBCG_DMA_BIT]
    |-> !gate_act_w[`PBCG_GATE_N-2])
    else $error("DMA clock ran while blocked");

  // A lane off on both sides must keep its gate shut
  for (genvar g = 0; g < `PBCG_GATE_N; g++) begin : g_chk
    AST_LANE_OFF: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      !applied_lane_w[g] && !gate_en_w[g] |-> !gate_act_w[g])
      else $error("Gated lane active while blocked");
  end
endmodule

// ==== pbcg_periph_model.sv ====
`timescale 1ns/10ps
module pbcg_periph_model #(
  parameter realtime HALF_NS = 12.5
) (
  // Reset
  input wire logic rst_n_i,
  // Gated clocks, one lane per peripheral
  input wire logic [21:0] gclk_i,
  // Activity seen by each peripheral
  output logic [21:0][15:0] cnt_o,
  output logic [21:0] short_o
);
  // ----------------------------------------
  // Lanes
  // ----------------------------------------
  for (genvar g = 0; g < 22; g++) begin : g_lane
    realtime t_rise = 0.0;
    // A lane works only on its own edges, so a blocked lane stays frozen
    always @(posedge gclk_i[g] or negedge rst_n_i) begin
      if (!rst_n_i) begin
        cnt_o[g] <= 16'h0000;
      end else begin
        cnt_o[g] <= cnt_o[g] + 16'h0001;
      end
    end
    always @(posedge gclk_i[g]) begin
      t_rise = $realtime;
    end
    // Flags a high pulse cut short by a gate change
    always @(negedge gclk_i[g] or negedge rst_n_i) begin
      if (!rst_n_i) begin
        short_o[g] <= 1'b0;
      end else if ($realtime - t_rise < HALF_NS - 0.1) begin
        short_o[g] <= 1'b1;
      end
    end
  end
endmodule

// ==== tb_top.sv ====
`timescale 1ns/10ps
`include "pbcg_defines.svh"
module tb_top;
  import pbcg_pkg::*;
  // ----------------------------------------
  // Signals
  // ----------------------------------------
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  pbcg_apb_req_t req = '0;
  pbcg_apb_rsp_t rsp;
  logic ext_clk, dma_clk;
  logic [3:0] conv_clk;
  logic [15:0] ser_clk;
  pbcg_enables_t applied;
  logic [21:0][15:0] cnt;
  logic [21:0][15:0] base;
  logic [21:0] short_flag;
  logic [31:0] rd;
  logic err;
  int num_errors = 0;
  int tests_run = 0;
  logic [31:0] pats [7] = '{32'h0400_0000, 32'h0100_0000, 32'h000A_0000, 32'h0005_8001,
    32'h0000_7FFE, 32'h050F_FFFF, 32'h0000_0000};

  always #12.5 clock_i = ~clock_i;

  pbcg_gate_ctrl i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .apb_req_i(req), .apb_rsp_o(rsp),
    .ext_bus_clk_o(ext_clk), .dma_clk_o(dma_clk), .converter_clk_o(conv_clk),
    .serial_chan_clk_o(ser_clk), .applied_o(applied));
  pbcg_periph_model i_periph (.rst_n_i(rst_n_i), .gclk_i({ext_clk, dma_clk, conv_clk, ser_clk}),
    .cnt_o(cnt), .short_o(short_flag));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  function automatic logic [21:0] lanes(input logic [31:0] v);
    return {v[26], v[24], v[19:16], v[15:0]};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] addr, input logic [31:0] wd);
    int n;
    @(posedge clock_i);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: addr, pwdata: wd};
    @(posedge clock_i);
    req.penable <= 1'b1;
    n = 0;
    @(posedge clock_i);
    while (rsp.pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge clock_i);
    end
    if (n >= 50) check(32'h0, 32'h1);
    rd = rsp.prdata;
    err = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  // Write, then poll until the readback agrees before using the peripheral
  task automatic settle(input logic [31:0] v);
    int n;
    apb(1'b1, `PBCG_OFF_ENABLE, v);
    check({31'h0, err}, 32'h0);
    n = 0;
    rd = ~v;
    while (rd !== (v & `PBCG_FIELD_MASK) && n < 20) begin
      n++;
      apb(1'b0, `PBCG_OFF_ENABLE, 32'h0);
    end
    check(rd, v & `PBCG_FIELD_MASK);
  endtask

  task automatic lanes_check(input logic [21:0] exp);
    @(negedge clock_i);
    base = cnt;
    repeat (8) @(negedge clock_i);
    for (int i = 0; i < 22; i++) begin
      check({16'h0, cnt[i] - base[i]}, exp[i] ? 32'h8 : 32'h0);
    end
  endtask

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge clock_i);
    check({10'h0, applied}, 32'h003F_FFFF);
    rst_n_i <= 1'b1;
    apb(1'b0, `PBCG_OFF_ENABLE, 32'h0);
    check(rd, `PBCG_ENABLE_RST);
    lanes_check(22'h3F_FFFF);
    foreach (pats[i]) begin
      settle(pats[i]);
      check({10'h0, applied}, {10'h0, lanes(pats[i])});
      lanes_check(lanes(pats[i]));
      apb(1'b0, `PBCG_OFF_REQUEST, 32'h0);
      check(rd, pats[i]);
      apb(1'b0, `PBCG_OFF_PENDING, 32'h0);
      check(rd, 32'h0);
    end
    // Every clock back on; reserved places are written as zero
    settle(32'h050F_FFFF);
    lanes_check(22'h3F_FFFF);
    apb(1'b0, 12'h00C, 32'h0);
    check({31'h0, err}, 32'h1);
    check(rd, 32'h0);
    apb(1'b1, `PBCG_OFF_REQUEST, 32'h0);
    check({31'h0, err}, 32'h1);
    apb(1'b0, `PBCG_OFF_ENABLE, 32'h0);
    check(rd, `PBCG_ENABLE_RST);
    // Reset in mid-run restores every clock
    settle(32'h0);
    @(posedge clock_i);
    rst_n_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    check({10'h0, applied}, 32'h003F_FFFF);
    rst_n_i <= 1'b1;
    lanes_check(22'h3F_FFFF);
    check({10'h0, short_flag}, 32'h0);
    print_verdict();
  end

  // Whole sequence takes under 3000 cycles
  initial begin
    repeat (20000) @(posedge clock_i);
    num_errors++;
    print_verdict();
  end
endmodule
